// [design/ecs_access.sv]
// ecs_access: code-memory read decode, config latch and serial programming gate
// assumes core reads are single-cycle requests and the main array sits outside
// Behaviour
// - commands and data cross two serial pins
// - identification bytes read at three code addresses
// - customer area readable through code reads
// - customer area not offered for data reads
// - customer area programmed like main memory
// - configuration latched at power up only
// - first configuration byte readable via data move
// - both protection bits erased: program and verify
// - first bit set: only second bit programmable
// - both bits set: verify also blocked
`timescale 1ns/1ps
module ecs_access #(
    parameter logic [7:0] SIG0 = 8'h11, // arbitrary value
    parameter logic [7:0] SIG1 = 8'h22, // arbitrary value
    parameter logic [7:0] SIG2 = 8'h33 // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // code-memory read instruction port
    input wire logic codeRdEn,
    input wire logic [15:0] codeRdAddr,
    output logic codeRdValid,
    output logic codeRdHit,
    output logic [7:0] codeRdData,
    // external data move read port
    input wire logic xdRdEn,
    input wire logic [15:0] xdRdAddr,
    output logic xdRdValid,
    output logic [7:0] xdRdData,
    // serial programming pins
    input wire logic progModePin,
    input wire logic progClkPin,
    input wire logic progDataRx,
    output logic progDataTx,
    output logic progDataEn,
    // main code array program and verify
    output logic mainProgReq,
    output logic mainVfyReq,
    output logic [15:0] mainAddr,
    output logic [7:0] mainWrData,
    input wire logic [7:0] mainVfyData,
    // latched configuration
    output logic cfgReady,
    output logic [7:0] cfgOne,
    output logic [7:0] cfgTwo,
    output logic [2:0] oscSel,
    output logic extClkSel,
    output logic protectProg,
    output logic protectVerify
);
    import ecs_pkg::*;

    // power-up sequence
    ecs_state_type state_q, state_d;
    logic [7:0] cfgOne_q; // first config byte
    logic [7:0] cfgTwo_q; // second config byte
    logic [1:0] secQ_q; // protection bits, 0 = programmed
    logic [2:0] oscSel_q; // oscillator choice
    logic extClk_q; // external clock chosen
    logic cfgReady_q; // latch complete
    logic protProg_q; // programming locked
    logic protVfy_q; // verify locked

    // core read pipeline
    logic s1Valid_q; // request in flight
    logic s1Cust_q; // answer from the store
    logic s1Sig_q; // answer is an id byte
    logic [7:0] s1Byte_q; // id byte in flight
    logic codeRdValid_q;
    logic codeRdHit_q;
    logic [7:0] codeRdData_q;
    logic xdRdValid_q;
    logic [7:0] xdRdData_q;

    // serial engine
    ecs_pins_type pinsS; // settled pins
    logic clkPrev_q; // last settled link clock
    ecs_frame_type frame_q; // shift register of frame
    logic [4:0] bitCnt_q; // bits received
    logic done_q; // full frame held
    logic vfy1_q; // reply stage one
    logic vfy2_q; // reply stage two
    ecs_src_type src_q; // reply source
    logic [7:0] sigSel_q; // id byte for reply
    logic [7:0] txShift_q; // reply shifter
    logic [2:0] txCnt_q; // reply bits sent
    logic txActive_q; // driving the data pin
    logic mainProg_q;
    logic mainVfy_q;
    logic [15:0] mainAddr_q;
    logic [7:0] mainData_q;

    // store port
    logic [7:0] memRdData;

    // raw pins gathered in carrier order: mode, clk, dat
    wire ecs_pins_type pinsIn = {progModePin, progClkPin, progDataRx};

    // pin synchroniser
    ecs_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .pinsRaw(pinsIn),
        .pinsOut(pinsS)
    );

    // state decode
    wire stRun = (state_q == ST_RUN);
    wire bootRd = (state_q == ST_CFG1) || (state_q == ST_CFG2) || (state_q == ST_SEC);
    wire [5:0] bootIdx = (state_q == ST_CFG1) ? IDX_CFG1 :
                         (state_q == ST_CFG2) ? IDX_CFG2 : IDX_SEC;
    wire progActive = stRun && pinsS.mode;
    wire linkRise = pinsS.clk && !clkPrev_q;

    // core read decode; only the code-read port reaches the customer area
    wire codeCust = isCust(codeRdAddr);
    wire coreMemRd = codeRdEn && codeCust && stRun && !pinsS.mode;
    wire [7:0] sigByte = (codeRdAddr == SIG_ADDR0) ? SIG0 :
                         (codeRdAddr == SIG_ADDR1) ? SIG1 : SIG2;
    wire codeSig = (codeRdAddr == SIG_ADDR0) || (codeRdAddr == SIG_ADDR1) ||
                   (codeRdAddr == SIG_ADDR2);

    // frame decode
    wire [15:0] fAddr = frame_q.addr;
    wire tgtCfg = (fAddr == CFG1_ADDR) || (fAddr == CFG2_ADDR);
    wire tgtSec = (fAddr == SEC_ADDR);
    wire tgtMem = isCust(fAddr) || tgtCfg || tgtSec;
    wire tgtMain = (fAddr < MAIN_LIMIT);
    wire tgtSig = (fAddr == SIG_ADDR0) || (fAddr == SIG_ADDR1) || (fAddr == SIG_ADDR2);
    wire isProg = (frame_q.cmd == CMD_PROG);
    wire isVfy = (frame_q.cmd == CMD_VERIFY);
    wire [7:0] fSig = (fAddr == SIG_ADDR0) ? SIG0 :
                      (fAddr == SIG_ADDR1) ? SIG1 : SIG2;

    // protection levels; second-bit-only locks nothing, so only bit one gates writes
    wire lockProg = !secQ_q[SB_FIRST];
    wire lockVfy = !secQ_q[SB_FIRST] && !secQ_q[SB_SECOND];
    wire progOk = lockProg ? tgtSec : 1'h1;
    wire doWrMem = done_q && isProg && progOk && tgtMem;
    wire doWrMain = done_q && isProg && progOk && tgtMain;
    wire doRdMem = done_q && isVfy && !lockVfy && tgtMem;
    wire doRdMain = done_q && isVfy && !lockVfy && tgtMain;
    wire ecs_src_type srcNext = doRdMem ? SRC_MEM : doRdMain ? SRC_MAIN :
                                (!lockVfy && tgtSig) ? SRC_SIG : SRC_NONE;

    // store access mux, power-up first, then link, then core
    wire memRdEn = bootRd || doRdMem || coreMemRd;
    wire [5:0] memRdIdx = bootRd ? bootIdx :
                          doRdMem ? memIndex(fAddr) : memIndex(codeRdAddr);

    // nonvolatile store
    ecs_nv_mem u_mem (
        .sys_clk(sys_clk),
        .rdEn(memRdEn),
        .rdIdx(memRdIdx),
        .rdData(memRdData),
        .wrEn(doWrMem),
        .wrIdx(memIndex(fAddr)),
        .wrData(frame_q.data)
    );

    // power-up sequence next state
    always_comb begin
        case (state_q)
            ST_CFG1: state_d = ST_CFG2;
            ST_CFG2: state_d = ST_SEC;
            ST_SEC: state_d = ST_DONE;
            ST_DONE: state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_CFG1;
        endcase
    end

    // configuration latched once after reset, never by the program
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_CFG1;
            cfgOne_q <= CFG1_RESET;
            cfgTwo_q <= CFG2_RESET;
            oscSel_q <= OSC_EXT;
            extClk_q <= 1'h1;
            cfgReady_q <= 1'h0;
        end else begin
            state_q <= state_d;
            if (state_q == ST_CFG2) begin
                cfgOne_q <= memRdData;
            end
            if (state_q == ST_SEC) begin
                cfgTwo_q <= memRdData;
            end
            if (state_q == ST_DONE) begin
                oscSel_q <= cfgOne_q[OSC_MSB:OSC_LSB];
                extClk_q <= (cfgOne_q[OSC_MSB:OSC_LSB] == OSC_EXT);
                cfgReady_q <= 1'h1;
            end
        end
    end

    // protection bits: loaded at power up, tightened by link writes
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            secQ_q <= SEC_RESET;
            protProg_q <= 1'h0;
            protVfy_q <= 1'h0;
        end else begin
            if (state_q == ST_DONE) begin
                secQ_q <= memRdData[SB_SECOND:SB_FIRST];
            end else if (doWrMem && tgtSec) begin
                secQ_q <= secQ_q & frame_q.data[SB_SECOND:SB_FIRST];
            end
            protProg_q <= lockProg;
            protVfy_q <= lockVfy;
        end
    end

    // core code read: answer two cycles after the request
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1Valid_q <= 1'h0;
            s1Cust_q <= 1'h0;
            s1Sig_q <= 1'h0;
            s1Byte_q <= BYTE_ZERO;
            codeRdValid_q <= 1'h0;
            codeRdHit_q <= 1'h0;
            codeRdData_q <= BYTE_ZERO;
        end else begin
            s1Valid_q <= codeRdEn;
            s1Cust_q <= coreMemRd;
            s1Sig_q <= codeRdEn && codeSig;
            s1Byte_q <= sigByte;
            codeRdValid_q <= s1Valid_q;
            codeRdHit_q <= s1Valid_q && (s1Cust_q || s1Sig_q);
            // unmapped reads, and customer-area reads while busy, answer zero; id bytes are answered even when busy
            if (s1Cust_q) begin
                codeRdData_q <= memRdData;
            end else if (s1Sig_q) begin
                codeRdData_q <= s1Byte_q;
            end else begin
                codeRdData_q <= BYTE_ZERO;
            end
        end
    end

    // data move read: one register, answer next cycle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            xdRdValid_q <= 1'h0;
            xdRdData_q <= BYTE_ZERO;
        end else begin
            xdRdValid_q <= xdRdEn;
            xdRdData_q <= (xdRdAddr == CFG1_ADDR) ? cfgOne_q : BYTE_ZERO;
        end
    end

    // frame receive on each settled link clock rise in programming mode while no reply is driven
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            clkPrev_q <= 1'h0;
            frame_q <= '0;
            bitCnt_q <= '0;
            done_q <= 1'h0;
        end else begin
            clkPrev_q <= pinsS.clk;
            done_q <= 1'h0;
            if (!progActive) begin
                bitCnt_q <= '0;
            end else if (linkRise && !txActive_q) begin
                frame_q <= {frame_q[$bits(ecs_frame_type)-2:0], pinsS.dat};
                bitCnt_q <= bitCnt_q + 5'h01;
                done_q <= (bitCnt_q == FRAME_LAST);
            end
        end
    end

    // command execution toward the main array
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            mainProg_q <= 1'h0;
            mainVfy_q <= 1'h0;
            mainAddr_q <= '0;
            mainData_q <= BYTE_ZERO;
        end else begin
            mainProg_q <= doWrMain;
            mainVfy_q <= doRdMain;
            if (doWrMain || doRdMain) begin
                mainAddr_q <= fAddr;
                mainData_q <= frame_q.data;
            end
        end
    end

    // verify reply: load after two cycles, then shift out msb first
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vfy1_q <= 1'h0;
            vfy2_q <= 1'h0;
            src_q <= SRC_NONE;
            sigSel_q <= BYTE_ZERO;
            txShift_q <= BYTE_ZERO;
            txCnt_q <= '0;
            txActive_q <= 1'h0;
        end else begin
            vfy1_q <= done_q && isVfy;
            vfy2_q <= vfy1_q;
            if (done_q && isVfy) begin
                src_q <= srcNext;
                sigSel_q <= fSig;
            end
            if (!progActive) begin
                txActive_q <= 1'h0;
            end else if (vfy2_q) begin
                // blocked or unmapped verify answers zero
                case (src_q)
                    SRC_MEM: txShift_q <= memRdData;
                    SRC_MAIN: txShift_q <= mainVfyData;
                    SRC_SIG: txShift_q <= sigSel_q;
                    SRC_NONE: txShift_q <= BYTE_ZERO;
                    default: txShift_q <= BYTE_ZERO;
                endcase
                txCnt_q <= '0;
                txActive_q <= 1'h1;
            end else if (txActive_q && linkRise) begin
                txShift_q <= {txShift_q[6:0], 1'h0};
                txCnt_q <= txCnt_q + 3'h1;
                txActive_q <= (txCnt_q != REPLY_LAST);
            end
        end
    end

    // outputs straight from flops
    assign codeRdValid = codeRdValid_q;
    assign codeRdHit = codeRdHit_q;
    assign codeRdData = codeRdData_q;
    assign xdRdValid = xdRdValid_q;
    assign xdRdData = xdRdData_q;
    assign progDataTx = txShift_q[7];
    assign progDataEn = txActive_q;
    assign mainProgReq = mainProg_q;
    assign mainVfyReq = mainVfy_q;
    assign mainAddr = mainAddr_q;
    assign mainWrData = mainData_q;
    assign cfgReady = cfgReady_q;
    assign cfgOne = cfgOne_q;
    assign cfgTwo = cfgTwo_q;
    assign oscSel = oscSel_q;
    assign extClkSel = extClk_q;
    assign protectProg = protProg_q;
    assign protectVerify = protVfy_q;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence s_vfy_req;
        done_q && isVfy;
    endsequence

    property p_sig_read;
        codeRdEn && (codeRdAddr == SIG_ADDR1) |-> ##2 codeRdValid && codeRdHit &&
            (codeRdData == SIG1);
    endproperty
    a_sig_read: assert property (p_sig_read) else $error("id byte read wrong");

    property p_cust_read;
        coreMemRd |-> ##2 codeRdHit && (codeRdData == $past(memRdData, 1));
    endproperty
    a_cust_read: assert property (p_cust_read) else $error("customer read wrong");

    property p_cfg_hold;
        cfgReady |=> $stable(cfgOne) && $stable(cfgTwo) && cfgReady;
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed in run");

    property p_xd_cfg;
        xdRdEn && (xdRdAddr == CFG1_ADDR) |=> xdRdValid && (xdRdData == cfgOne);
    endproperty
    a_xd_cfg: assert property (p_xd_cfg) else $error("config byte read wrong");

    property p_prog_open;
        done_q && isProg && secQ_q[SB_FIRST] && tgtMain |=> mainProgReq &&
            (mainAddr == $past(fAddr));
    endproperty
    a_prog_open: assert property (p_prog_open) else $error("open write dropped");

    property p_prog_lock;
        done_q && isProg && !secQ_q[SB_FIRST] && !tgtSec |-> !doWrMem ##1 !mainProgReq;
    endproperty
    a_prog_lock: assert property (p_prog_lock) else $error("locked write taken");

    property p_vfy_block;
        s_vfy_req and lockVfy |-> ##1 !mainVfyReq ##2 (txShift_q == BYTE_ZERO) && progDataEn;
    endproperty
    a_vfy_block: assert property (p_vfy_block) else $error("blocked verify leaked");

    property p_osc;
        cfgReady |-> extClkSel == (cfgOne[OSC_MSB:OSC_LSB] == OSC_EXT);
    endproperty
    a_osc: assert property (p_osc) else $error("clock select wrong");

    property p_reply_drive;
        s_vfy_req and progActive |-> ##3 progDataEn;
    endproperty
    a_reply_drive: assert property (p_reply_drive) else $error("reply not driven");

endmodule : ecs_access

// [pkg/ecs_pkg.sv]
// ecs_pkg: constants, carriers and helpers of the code-memory access block
// assumes a 16-bit code/data address space and 8-bit data
package ecs_pkg;

    // identification byte locations in code space
    localparam logic [15:0] SIG_ADDR0 = 16'hFC30;
    localparam logic [15:0] SIG_ADDR1 = 16'hFC31;
    localparam logic [15:0] SIG_ADDR2 = 16'hFC60;
    // customer area bounds in code space
    localparam logic [15:0] CUST_BASE = 16'hFCE0;
    localparam logic [15:0] CUST_LAST = 16'hFCFF;
    // configuration and protection locations
    localparam logic [15:0] CFG1_ADDR = 16'hFD00;
    localparam logic [15:0] CFG2_ADDR = 16'hFD01;
    localparam logic [15:0] SEC_ADDR = 16'hFD02;
    // main code array lies below this address
    localparam logic [15:0] MAIN_LIMIT = 16'hFC00;

    // nonvolatile store layout
    localparam int MEM_DEPTH = 64;
    localparam logic [5:0] IDX_CFG1 = 6'h20;
    localparam logic [5:0] IDX_CFG2 = 6'h21;
    localparam logic [5:0] IDX_SEC = 6'h22;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // reset values of latched configuration
    localparam logic [7:0] CFG1_RESET = 8'hFF;
    localparam logic [7:0] CFG2_RESET = 8'hFF;
    localparam logic [1:0] SEC_RESET = 2'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // field positions
    localparam int OSC_LSB = 0;
    localparam int OSC_MSB = 2;
    localparam logic [2:0] OSC_EXT = 3'h7;
    localparam int SB_FIRST = 0;
    localparam int SB_SECOND = 1;

    // serial link commands and counts
    localparam logic [7:0] CMD_PROG = 8'h01;
    localparam logic [7:0] CMD_VERIFY = 8'h02;
    localparam logic [4:0] FRAME_LAST = 5'h1F;
    localparam logic [2:0] REPLY_LAST = 3'h7;

    // synchronised programming pins
    typedef struct packed {
        logic mode;
        logic clk;
        logic dat;
    } ecs_pins_type;

    // one received command frame, command first
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [7:0] data;
    } ecs_frame_type;

    // power-up sequence states
    typedef enum logic [4:0] {
        ST_CFG1 = 5'b00001,
        ST_CFG2 = 5'b00010,
        ST_SEC = 5'b00100,
        ST_DONE = 5'b01000,
        ST_RUN = 5'b10000
    } ecs_state_type;

    // source of a verify reply byte
    typedef enum logic [3:0] {
        SRC_NONE = 4'b0001,
        SRC_MEM = 4'b0010,
        SRC_MAIN = 4'b0100,
        SRC_SIG = 4'b1000
    } ecs_src_type;

    // address falls in the customer area
    function automatic logic isCust(input logic [15:0] a);
        isCust = (a >= CUST_BASE) && (a <= CUST_LAST);
    endfunction : isCust

    // store index of a nonvolatile location
    function automatic logic [5:0] memIndex(input logic [15:0] a);
        if (a == CFG1_ADDR) begin
            memIndex = IDX_CFG1;
        end else if (a == CFG2_ADDR) begin
            memIndex = IDX_CFG2;
        end else if (a == SEC_ADDR) begin
            memIndex = IDX_SEC;
        end else begin
            memIndex = {1'h0, a[4:0]};
        end
    endfunction : memIndex

endpackage : ecs_pkg

// [design/ecs_pin_sync.sv]
// ecs_pin_sync: three-flop synchroniser for the programming pins
// assumes pins are asynchronous to sys_clk; output changes once stages 2 and 3 agree
`timescale 1ns/1ps
module ecs_pin_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // raw and settled pins
    input wire ecs_pkg::ecs_pins_type pinsRaw,
    output ecs_pkg::ecs_pins_type pinsOut
);
    import ecs_pkg::*;

    ecs_pins_type st1_q; // first stage, read only by st2
    ecs_pins_type st2_q; // second stage
    ecs_pins_type st3_q; // third stage
    ecs_pins_type out_q; // settled value

    // per-bit agreement of the two later stages
    wire ecs_pins_type agree = ~(st2_q ^ st3_q);

    // shift chain and qualified update
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st1_q <= '0;
            st2_q <= '0;
            st3_q <= '0;
            out_q <= '0;
        end else begin
            st1_q <= pinsRaw;
            st2_q <= st1_q;
            st3_q <= st2_q;
            out_q <= (agree & st3_q) | (~agree & out_q);
        end
    end

    assign pinsOut = out_q;

endmodule : ecs_pin_sync

// [design/ecs_nv_mem.sv]
// ecs_nv_mem: small one-time-programmable store (customer area, config, protection)
// assumes one access per cycle; programming can only clear bits
`timescale 1ns/1ps
module ecs_nv_mem (
    // clock
    input wire logic sys_clk,
    // read port, data registered
    input wire logic rdEn,
    input wire logic [5:0] rdIdx,
    output logic [7:0] rdData,
    // program port
    input wire logic wrEn,
    input wire logic [5:0] wrIdx,
    input wire logic [7:0] wrData
);
    import ecs_pkg::*;

    // storage cells start erased; only the clocked process below writes them
    logic [7:0] mem [MEM_DEPTH] = '{default: ERASED_BYTE};
    logic [7:0] rdData_q; // read register

    // programming ands in, so a 0 never returns to 1
    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrIdx] <= mem[wrIdx] & wrData;
        end
        if (rdEn) begin
            rdData_q <= mem[rdIdx];
        end
    end

    assign rdData = rdData_q;

endmodule : ecs_nv_mem

// [dv/ecs_prog_model.sv]
// ecs_prog_model: serial programmer on the far side of the link
// assumes the bench resolves the shared data wire with a pull-up
`timescale 1ns/1ps
module ecs_prog_model (
    // core clock for pacing
    input wire logic sys_clk,
    // resolved data wire
    input wire logic pinWire,
    // programmer pins
    output logic progModePin,
    output logic progClkPin,
    output logic mdlEn,
    output logic mdlDat
);
    // one link clock level, seven core cycles
    task automatic half();
        repeat (7) @(posedge sys_clk);
        #1;
    endtask : half
    // enter or leave programming mode
    task automatic mode(input logic on);
        progModePin = on;
        repeat (4) half();
    endtask : mode
    // one frame, msb first, clock idles low
    task automatic frame(input logic [31:0] f);
        mdlEn = 1'h1;
        for (int i = 31; i >= 0; i--) begin
            mdlDat = f[i];
            half();
            progClkPin = 1'h1;
            repeat (5) @(posedge sys_clk);
            #1 mdlEn = (i != 0); // release before the reply
            half();
            progClkPin = 1'h0;
        end
        half();
    endtask : frame
    // eight rises read a reply byte
    task automatic reply(output logic [7:0] b);
        half();
        for (int i = 7; i >= 0; i--) begin
            b[i] = pinWire;
            progClkPin = 1'h1;
            half();
            progClkPin = 1'h0;
            half();
        end
    endtask : reply
    // idle pins
    initial begin
        progModePin = 1'h0;
        progClkPin = 1'h0;
        mdlEn = 1'h0;
        mdlDat = 1'h0;
    end
endmodule : ecs_prog_model

// [dv/tb_top.sv]
// tb_top: self-checking bench of the code-memory access block
// assumes the programmer model drives the link; the bench models the main array
`timescale 1ns/1ps
module tb_top;
    import ecs_pkg::*;
    // core side
    logic sys_clk, rst_b, codeRdEn, xdRdEn, codeRdValid, codeRdHit, xdRdValid;
    logic [15:0] codeRdAddr, xdRdAddr, mainAddr;
    logic [7:0] codeRdData, xdRdData, mainWrData, mainVfyData, cfgOne, cfgTwo;
    logic [2:0] oscSel;
    logic progModePin, progClkPin, progDataRx, progDataTx, progDataEn, mdlEn, mdlDat;
    logic mainProgReq, mainVfyReq, cfgReady, extClkSel, protectProg, protectVerify;
    int num_errors = 0, cmp_count = 0, progCnt = 0, vfyCnt = 0, cyc = 0;
    logic [7:0] rb;
    // data wire with pull-up
    assign progDataRx = mdlEn ? mdlDat : (progDataEn ? progDataTx : 1'h1);
    ecs_access u_dut (.sys_clk, .rst_b, .codeRdEn, .codeRdAddr, .codeRdValid,
        .codeRdHit, .codeRdData, .xdRdEn, .xdRdAddr, .xdRdValid, .xdRdData,
        .progModePin, .progClkPin, .progDataRx, .progDataTx, .progDataEn,
        .mainProgReq, .mainVfyReq, .mainAddr, .mainWrData, .mainVfyData,
        .cfgReady, .cfgOne, .cfgTwo, .oscSel, .extClkSel, .protectProg,
        .protectVerify);
    ecs_prog_model u_prog (.sys_clk, .pinWire(progDataRx), .progModePin,
        .progClkPin, .mdlEn, .mdlDat);
    // clock
    initial begin
        sys_clk = 1'h0;
        forever #50 sys_clk = ~sys_clk;
    end
    // main array: data the cycle after a verify strobe, then toggling
    always @(posedge sys_clk) begin
        cyc++;
        if (mainProgReq) progCnt++;
        if (mainVfyReq) vfyCnt++;
        mainVfyData <= #1 mainVfyReq ? ~mainAddr[7:0] : ~mainVfyData;
        if (cyc == 30000) begin
            num_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic do_reset();
        #1 rst_b = 1'h0;
        repeat (8) @(posedge sys_clk);
        #1 rst_b = 1'h1;
        repeat (8) @(posedge sys_clk);
        #1;
        check("cfgReady", cfgReady, 1'h1);
    endtask : do_reset
    // code read: valid one edge after the take edge
    task automatic code_rd(input logic [15:0] a, input logic h, input logic [7:0] d);
        codeRdEn = 1'h1;
        codeRdAddr = a;
        @(posedge sys_clk);
        #1 codeRdEn = 1'h0;
        @(posedge sys_clk);
        #1;
        check("codeRdValid", codeRdValid, 1'h1);
        check("codeRdHit", codeRdHit, h);
        check("codeRdData", codeRdData, d);
    endtask : code_rd
    // data move read: answer right after the take edge
    task automatic xd_rd(input logic [15:0] a, input logic [7:0] d);
        xdRdEn = 1'h1;
        xdRdAddr = a;
        @(posedge sys_clk);
        #1 xdRdEn = 1'h0;
        check("xdRdValid", xdRdValid, 1'h1);
        check("xdRdData", xdRdData, d);
        // idle edge so a following read does not re-raise the strobe at once
        @(posedge sys_clk);
        #1;
    endtask : xd_rd
    task automatic vfy(input logic [15:0] a, input logic [7:0] d);
        u_prog.frame({CMD_VERIFY, a, 8'h00});
        u_prog.reply(rb);
        check("reply", rb, d);
    endtask : vfy
    task automatic t_power();
        check("cfgOne", cfgOne, 8'hFF);
        check("cfgTwo", cfgTwo, 8'hFF);
        check("oscSel", oscSel, 3'h7);
        check("extClkSel", extClkSel, 1'h1);
        xd_rd(CFG1_ADDR, 8'hFF);
        xd_rd(CFG2_ADDR, 8'h00);
    endtask : t_power
    task automatic t_read();
        code_rd(SIG_ADDR0, 1'h1, 8'h11);
        code_rd(SIG_ADDR1, 1'h1, 8'h22);
        code_rd(SIG_ADDR2, 1'h1, 8'h33);
        code_rd(CUST_BASE, 1'h1, 8'hFF);
        code_rd(CUST_LAST, 1'h1, 8'hFF);
        code_rd(16'hFC32, 1'h0, 8'h00);
    endtask : t_read
    task automatic t_prog();
        u_prog.mode(1'h1);
        u_prog.frame({CMD_PROG, 16'hFCE5, 8'h3C});
        u_prog.frame({CMD_PROG, 16'h0123, 8'h55});
        check("progCnt", progCnt, 16'h1);
        check("mainAddr", mainAddr, 16'h0123);
        check("mainWrData", mainWrData, 8'h55);
        vfy(16'h0040, 8'hBF);
        check("vfyCnt", vfyCnt, 16'h1);
        u_prog.frame({CMD_PROG, CFG1_ADDR, 8'hFE});
        vfy(CFG1_ADDR, 8'hFE);
        u_prog.mode(1'h0);
        code_rd(16'hFCE5, 1'h1, 8'h3C);
        xd_rd(CFG1_ADDR, 8'hFF);
    endtask : t_prog
    task automatic t_lock();
        u_prog.mode(1'h1);
        u_prog.frame({CMD_PROG, SEC_ADDR, 8'hFE});
        check("protectProg", protectProg, 1'h1);
        u_prog.frame({CMD_PROG, 16'h0124, 8'h66});
        u_prog.frame({CMD_PROG, 16'hFCE6, 8'h00});
        check("progCnt", progCnt, 16'h1);
        vfy(16'h0041, 8'hBE);
        u_prog.frame({CMD_PROG, SEC_ADDR, 8'hFC});
        check("protectVerify", protectVerify, 1'h1);
        vfy(16'h0042, 8'h00);
        check("vfyCnt", vfyCnt, 16'h2);
        u_prog.mode(1'h0);
        code_rd(16'hFCE6, 1'h1, 8'hFF);
    endtask : t_lock
    task automatic t_repower();
        check("cfgOne", cfgOne, 8'hFE);
        check("cfgTwo", cfgTwo, 8'hFF);
        check("oscSel", oscSel, 3'h6);
        check("extClkSel", extClkSel, 1'h0);
        check("protectVerify", protectVerify, 1'h1);
        xd_rd(CFG1_ADDR, 8'hFE);
    endtask : t_repower
    // main sequence
    initial begin
        rst_b = 1'h0;
        codeRdEn = 1'h0;
        xdRdEn = 1'h0;
        codeRdAddr = 16'h0000;
        xdRdAddr = 16'h0000;
        mainVfyData = 8'h00;
        do_reset();
        t_power();
        t_read();
        t_prog();
        t_lock();
        do_reset();
        t_repower();
        finish_test();
    end
endmodule : tb_top
